// ===== hw/hci_top.sv
// Host command interpreter: setpoint change, status, mode, faults, forcing
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Setpoint write replaces second instruction word at a five-digit address.
// - Operand banks io, link, holding, aux accepted within their word ranges.
// - Setpoint is data or extended store address, or literal, range checked.
// - Extended store operands are valid only on the variant with that bank.
// - Status answer holds mode byte high and program size byte low.
// - Status answer carries alarm number present, flagged absent when none.
// - Fault read clears errors on 01, leaves them on 00, then reports.
// - Fatal errors are cleared only while in program mode.
// - Fault read returns two error words.
// - Fault read reports whether previously reported errors were cleared.
// - Force-on sets one bit in one bank per command.
// - Force-off resets one bit in one bank per command.
// - A forced bit keeps its state until clear-all or a later force.
// - End code 00 means normal completion, anything else abnormal.
// - Clear-all releases every forced bit at once.
module hci_top #(
  parameter bit HAS_EXT_STORE = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [hci_pkg::ADDR_W-1:0] addr_i,
  input wire logic [hci_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [hci_pkg::DATA_W-1:0] rdata_o,
  // Controller state inputs
  input wire logic [7:0] prog_size_i,
  input wire logic alarm_valid_i,
  input wire logic [7:0] alarm_num_i,
  input wire logic [31:0] err_evt_i,
  // Program memory write port
  output logic prog_wr_o,
  output logic [19:0] prog_addr_o,
  output hci_pkg::hci_instr_e prog_instr_o,
  output logic [15:0] prog_tc_o,
  output hci_pkg::hci_bank_e prog_opnd_o,
  output logic [15:0] prog_val_o,
  // Force port towards the bit memory
  output logic force_wr_o,
  output hci_pkg::hci_bank_e force_bank_o,
  output logic [15:0] force_word_o,
  output logic [3:0] force_bit_o,
  output logic force_val_o,
  output logic force_clr_o,
  // Operating mode
  output logic [1:0] mode_o
);
  import hci_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] name;
    logic [19:0] addr;
    logic [15:0] num;
    logic [31:0] opnd;
    logic [15:0] val;
    logic [7:0] end_code;
    logic [31:0] resp0;
    logic [31:0] resp1;
    logic [1:0] mode;
    logic [31:0] err;
    logic [31:0] rep;
    logic [31:0] rdata;
    logic prog_wr;
    logic [19:0] prog_addr;
    hci_instr_e prog_instr;
    logic [15:0] prog_tc;
    hci_bank_e prog_opnd;
    logic [15:0] prog_val;
    logic force_wr;
    hci_bank_e force_bank;
    logic [15:0] force_word;
    logic [3:0] force_bit;
    logic force_val;
    logic force_clr;
  } hci_state_s;

  hci_state_s st_r;
  hci_state_s st_nxt;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // True when every nibble is a decimal digit
  function automatic logic bcd_ok(input logic [19:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      if (v[4*i +: 4] > 4'h9)
        ok = 1'b0;
    end
    return ok;
  endfunction : bcd_ok

  // Instruction kind from its four-character name
  function automatic hci_instr_e dec_instr(input logic [31:0] n);
    case (n)
      NM_DELAY: return IN_DELAY;
      NM_FAST_DELAY: return IN_FAST_DELAY;
      NM_ACC_DELAY: return IN_ACC_DELAY;
      NM_DOWN_COUNT: return IN_DOWN;
      NM_UPDN_COUNT: return IN_UPDN;
      default: return IN_NONE;
    endcase
  endfunction : dec_instr

  // Bank kind from its space-padded name
  function automatic hci_bank_e dec_bank(input logic [31:0] n);
    case (n)
      NM_IO: return BK_IO;
      NM_LINK: return BK_LINK;
      NM_HOLD: return BK_HOLD;
      NM_AUX: return BK_AUX;
      NM_DATA: return BK_DATA;
      NM_DATA_IND: return BK_DATA_IND;
      NM_EXT: return BK_EXT;
      NM_EXT_IND: return BK_EXT_IND;
      NM_LITERAL: return BK_LITERAL;
      default: return BK_NONE;
    endcase
  endfunction : dec_bank

  // Upper BCD limit of a bank; BCD compares like decimal once digits are valid
  function automatic logic [15:0] bank_lim(input hci_bank_e b);
    case (b)
      BK_IO: return LIM_IO;
      BK_LINK: return LIM_LINK;
      BK_HOLD: return LIM_HOLD;
      BK_AUX: return LIM_AUX;
      BK_DATA, BK_DATA_IND: return LIM_DATA;
      BK_EXT, BK_EXT_IND: return LIM_EXT;
      BK_LITERAL: return LIM_LITERAL;
      BK_DELAY_COUNT: return LIM_TC;
      default: return 16'h0000;
    endcase
  endfunction : bank_lim

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // Commands execute in the cycle the command register is written, so an
  // answer is ready before any following read can reach the port.
  always_comb
  begin
    hci_instr_e ins;
    hci_bank_e bk;
    logic [31:0] clr;
    logic [3:0] bit_bin;
    ins = dec_instr(st_r.name);
    bk = dec_bank(st_r.opnd);
    clr = 32'h0000_0000;
    bit_bin = 4'h0;
    st_nxt = st_r;
    st_nxt.rdata = 32'h0000_0000;
    st_nxt.prog_wr = 1'b0;
    st_nxt.force_wr = 1'b0;
    st_nxt.force_clr = 1'b0;
    if (rd_i)
    begin
      case (addr_i)
        REG_NAME: st_nxt.rdata = st_r.name;
        REG_ADDR: st_nxt.rdata = {12'h000, st_r.addr};
        REG_NUM: st_nxt.rdata = {16'h0000, st_r.num};
        REG_OPND: st_nxt.rdata = st_r.opnd;
        REG_VAL: st_nxt.rdata = {16'h0000, st_r.val};
        REG_END: st_nxt.rdata = {24'h000000, st_r.end_code};
        REG_RESP0: st_nxt.rdata = st_r.resp0;
        REG_RESP1: st_nxt.rdata = st_r.resp1;
        REG_MODE: st_nxt.rdata = {30'h0000_0000, st_r.mode};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_i)
    begin
      case (addr_i)
        REG_NAME: st_nxt.name = wdata_i;
        REG_ADDR: st_nxt.addr = wdata_i[19:0];
        REG_NUM: st_nxt.num = wdata_i[15:0];
        REG_OPND: st_nxt.opnd = wdata_i;
        REG_VAL: st_nxt.val = wdata_i[15:0];
        REG_CMD:
        begin
          st_nxt.end_code = END_CMD_ERR;
          st_nxt.resp0 = 32'h0000_0000;
          st_nxt.resp1 = 32'h0000_0000;
          case (wdata_i[3:0])
            CMD_SETPOINT:
            begin
              // Names and every field are checked before memory moves
              if (ins == IN_NONE || bk == BK_NONE)
                st_nxt.end_code = END_NAME_ERR;
              else if (!bcd_ok(st_r.addr) || !bcd_ok({4'h0, st_r.num})
                       || st_r.num > LIM_TC)
                st_nxt.end_code = END_RANGE_ERR;
              else if (!HAS_EXT_STORE && (bk == BK_EXT || bk == BK_EXT_IND))
                st_nxt.end_code = END_NAME_ERR;
              else if (!bcd_ok({4'h0, st_r.val})
                       || st_r.val > bank_lim(bk))
                st_nxt.end_code = END_RANGE_ERR;
              else
              begin
                // Second word of the instruction at the address
                st_nxt.prog_wr = 1'b1;
                st_nxt.prog_addr = st_r.addr;
                st_nxt.prog_instr = ins;
                st_nxt.prog_tc = st_r.num;
                st_nxt.prog_opnd = bk;
                st_nxt.prog_val = st_r.val;
                st_nxt.end_code = END_OK;
              end
            end
            CMD_STATE_QUERY:
            begin
              // Mode byte high, program size byte low
              st_nxt.resp0 = {16'h0000, st_r.mode, 6'h00, prog_size_i};
              // Bit 8 tells the framer whether the alarm field exists
              st_nxt.resp1 = {23'h000000, alarm_valid_i,
                              alarm_valid_i ? alarm_num_i : 8'h00};
              st_nxt.end_code = END_OK;
            end
            CMD_MODE_WRITE:
            begin
              // Stray low bits are refused rather than ignored
              if (st_r.val[15:8] != 8'h00 || st_r.val[MODE_POS-1:0] != 6'h00)
                st_nxt.end_code = END_RANGE_ERR;
              else
              begin
                st_nxt.mode = st_r.val[MODE_POS +: 2];
                st_nxt.end_code = END_OK;
              end
            end
            CMD_FAULT_READ:
            begin
              if (st_r.val[7:0] == CLR_YES)
              begin
                clr[15:0] = 16'hFFFF;
                // Fatal word survives outside program mode
                if (st_r.mode == MODE_PROGRAM)
                  clr[31:16] = 16'hFFFF;
              end
              if (st_r.val[15:8] != 8'h00 || (st_r.val[7:0] != CLR_YES
                  && st_r.val[7:0] != CLR_NO))
              begin
                clr = 32'h0000_0000;
                st_nxt.end_code = END_RANGE_ERR;
              end
              else
              begin
                // Two error words after the clear
                st_nxt.resp0 = (st_r.err & ~clr) | err_evt_i;
                // Flag: errors reported last time are all gone
                st_nxt.resp1 = {31'h0000_0000,
                                ((st_r.rep & st_nxt.resp0) == 32'h0)};
                st_nxt.rep = st_nxt.resp0;
                st_nxt.end_code = END_OK;
              end
            end
            CMD_FORCE_ON, CMD_FORCE_OFF:
            begin
              // Delay/count names pick the completion flag bank
              bk = (dec_instr(st_r.name) != IN_NONE) ? BK_DELAY_COUNT
                   : dec_bank(st_r.name);
              bit_bin = 4'(st_r.num[7:4] * 4'hA + st_r.num[3:0]);
              if (!(bk inside {BK_IO, BK_LINK, BK_HOLD, BK_AUX,
                               BK_DELAY_COUNT}))
                st_nxt.end_code = END_NAME_ERR;
              else if (!bcd_ok({4'h0, st_r.addr[15:0]})
                       || st_r.addr[19:16] != 4'h0
                       || st_r.addr[15:0] > bank_lim(bk)
                       || !bcd_ok({12'h000, st_r.num[7:0]})
                       || st_r.num[15:8] != 8'h00
                       || st_r.num[7:0] > LIM_BIT
                       || (bk == BK_DELAY_COUNT && st_r.num[7:0] != TC_BIT))
                st_nxt.end_code = END_RANGE_ERR;
              else
              begin
                // One bit per command; a later force overrides it
                st_nxt.force_wr = 1'b1;
                st_nxt.force_bank = bk;
                st_nxt.force_word = st_r.addr[15:0];
                st_nxt.force_bit = bit_bin;
                st_nxt.force_val = (wdata_i[3:0] == CMD_FORCE_ON);
                st_nxt.end_code = END_OK;
              end
            end
            CMD_FORCE_CLEAR_ALL:
            begin
              st_nxt.force_clr = 1'b1;
              st_nxt.end_code = END_OK;
            end
            default: st_nxt.end_code = END_CMD_ERR;
          endcase
        end
        default: st_nxt.end_code = st_r.end_code;
      endcase
    end
    // Sticky errors; a new event wins over a clear in the same cycle
    st_nxt.err = (st_r.err & ~clr) | err_evt_i;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_r <= '0;
      st_r.end_code <= END_RESET;
      st_r.mode <= MODE_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign rdata_o = st_r.rdata;
  assign prog_wr_o = st_r.prog_wr;
  assign prog_addr_o = st_r.prog_addr;
  assign prog_instr_o = st_r.prog_instr;
  assign prog_tc_o = st_r.prog_tc;
  assign prog_opnd_o = st_r.prog_opnd;
  assign prog_val_o = st_r.prog_val;
  assign force_wr_o = st_r.force_wr;
  assign force_bank_o = st_r.force_bank;
  assign force_word_o = st_r.force_word;
  assign force_bit_o = st_r.force_bit;
  assign force_val_o = st_r.force_val;
  assign force_clr_o = st_r.force_clr;
  assign mode_o = st_r.mode;

endmodule : hci_top

`default_nettype wire

// ===== common/hci_pkg.sv
// Package of constants and types for the host command interpreter
package hci_pkg;

  // --------------------------------------------------------------
  // Register bus geometry and register indices
  // --------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_NAME = 4'h1;
  localparam logic [3:0] REG_ADDR = 4'h2;
  localparam logic [3:0] REG_NUM = 4'h3;
  localparam logic [3:0] REG_OPND = 4'h4;
  localparam logic [3:0] REG_VAL = 4'h5;
  localparam logic [3:0] REG_END = 4'h6;
  localparam logic [3:0] REG_RESP0 = 4'h7;
  localparam logic [3:0] REG_RESP1 = 4'h8;
  localparam logic [3:0] REG_MODE = 4'h9;

  // --------------------------------------------------------------
  // Command codes written to the command register
  // --------------------------------------------------------------
  localparam logic [3:0] CMD_SETPOINT = 4'h1;
  localparam logic [3:0] CMD_STATE_QUERY = 4'h2;
  localparam logic [3:0] CMD_MODE_WRITE = 4'h3;
  localparam logic [3:0] CMD_FAULT_READ = 4'h4;
  localparam logic [3:0] CMD_FORCE_ON = 4'h5;
  localparam logic [3:0] CMD_FORCE_OFF = 4'h6;
  localparam logic [3:0] CMD_FORCE_CLEAR_ALL = 4'h7;

  // --------------------------------------------------------------
  // End codes
  // --------------------------------------------------------------
  localparam logic [7:0] END_OK = 8'h00;
  localparam logic [7:0] END_NAME_ERR = 8'h14;
  localparam logic [7:0] END_RANGE_ERR = 8'h15;
  localparam logic [7:0] END_CMD_ERR = 8'h16;
  localparam logic [7:0] END_RESET = 8'h00;

  // --------------------------------------------------------------
  // Four-character ASCII names
  // --------------------------------------------------------------
  localparam logic [31:0] NM_DELAY = 32'h54494D20;
  localparam logic [31:0] NM_FAST_DELAY = 32'h54494D48;
  localparam logic [31:0] NM_ACC_DELAY = 32'h5454494D;
  localparam logic [31:0] NM_DOWN_COUNT = 32'h434E5420;
  localparam logic [31:0] NM_UPDN_COUNT = 32'h434E5452;
  localparam logic [31:0] NM_IO = 32'h43494F20;
  localparam logic [31:0] NM_LINK = 32'h4C522020;
  localparam logic [31:0] NM_HOLD = 32'h48522020;
  localparam logic [31:0] NM_AUX = 32'h41522020;
  localparam logic [31:0] NM_DATA = 32'h444D2020;
  localparam logic [31:0] NM_DATA_IND = 32'h444D2A20;
  localparam logic [31:0] NM_EXT = 32'h454D2020;
  localparam logic [31:0] NM_EXT_IND = 32'h454D2A20;
  localparam logic [31:0] NM_LITERAL = 32'h434F4E20;

  // --------------------------------------------------------------
  // BCD upper limits of address, value, timer and bit fields, flag bit number and fault clear codes
  // --------------------------------------------------------------
  localparam logic [15:0] LIM_IO = 16'h0252;
  localparam logic [15:0] LIM_LINK = 16'h0063;
  localparam logic [15:0] LIM_HOLD = 16'h0099;
  localparam logic [15:0] LIM_AUX = 16'h0027;
  localparam logic [15:0] LIM_DATA = 16'h6655;
  localparam logic [15:0] LIM_EXT = 16'h6143;
  localparam logic [15:0] LIM_LITERAL = 16'h9999;
  localparam logic [15:0] LIM_TC = 16'h0511;
  localparam logic [7:0] LIM_BIT = 8'h15;
  localparam logic [7:0] TC_BIT = 8'h00;
  localparam logic [7:0] CLR_YES = 8'h01;
  localparam logic [7:0] CLR_NO = 8'h00;

  // --------------------------------------------------------------
  // Operating mode field and reset values
  // --------------------------------------------------------------
  localparam logic [1:0] MODE_PROGRAM = 2'b00;
  localparam logic [1:0] MODE_RESET = 2'b00;
  localparam int MODE_POS = 6;

  // Instruction kinds and bank kinds
  typedef enum logic [2:0] {
    IN_NONE, IN_DELAY, IN_FAST_DELAY, IN_ACC_DELAY, IN_DOWN, IN_UPDN
  } hci_instr_e;
  typedef enum logic [3:0] {
    BK_NONE, BK_IO, BK_LINK, BK_HOLD, BK_AUX, BK_DATA, BK_DATA_IND,
    BK_EXT, BK_EXT_IND, BK_LITERAL, BK_DELAY_COUNT
  } hci_bank_e;

endpackage : hci_pkg

// ===== verif/hci_top_monitor.sv
// Port checker of the host command interpreter, bound into the design
`timescale 1ns/100ps
`default_nettype none
module hci_top_monitor #(
  parameter bit HAS_EXT_STORE = 1'b0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [hci_pkg::ADDR_W-1:0] addr_i,
  input wire logic [hci_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  // Command outputs
  input wire logic prog_wr_o,
  input wire logic [15:0] prog_tc_o,
  input wire hci_pkg::hci_bank_e prog_opnd_o,
  input wire logic [15:0] prog_val_o,
  input wire logic force_wr_o,
  input wire hci_pkg::hci_bank_e force_bank_o,
  input wire logic [15:0] force_word_o,
  input wire logic [3:0] force_bit_o,
  input wire logic force_val_o,
  input wire logic force_clr_o,
  input wire logic [1:0] mode_o
);
  import hci_pkg::*;
  logic go_setp, go_on, go_off, go_mode, go_clr;
  // Decoded command strobes, one per code except status query and fault read
  assign go_setp = wr_i && addr_i == REG_CMD && wdata_i[3:0] == CMD_SETPOINT;
  assign go_on = wr_i && addr_i == REG_CMD && wdata_i[3:0] == CMD_FORCE_ON;
  assign go_off = wr_i && addr_i == REG_CMD && wdata_i[3:0] == CMD_FORCE_OFF;
  assign go_mode = wr_i && addr_i == REG_CMD && wdata_i[3:0] == CMD_MODE_WRITE;
  assign go_clr = wr_i && addr_i == REG_CMD &&
    wdata_i[3:0] == CMD_FORCE_CLEAR_ALL;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_setp; prog_wr_o |-> $past(go_setp); endproperty
  a_setp: assert property (p_setp)
    else $error("setpoint write without command");
  property p_tc; prog_wr_o |-> prog_tc_o <= LIM_TC; endproperty
  a_tc: assert property (p_tc)
    else $error("timer number over range");
  property p_lit;
    prog_wr_o && prog_opnd_o == BK_LITERAL |-> prog_val_o <= LIM_LITERAL;
  endproperty
  a_lit: assert property (p_lit)
    else $error("literal over range");
  property p_ext;
    prog_wr_o && !HAS_EXT_STORE |-> !(prog_opnd_o inside {BK_EXT, BK_EXT_IND});
  endproperty
  a_ext: assert property (p_ext)
    else $error("extended store on variant without it");
  property p_mode; !go_mode |=> $stable(mode_o); endproperty
  a_mode: assert property (p_mode)
    else $error("mode changed without mode write");
  property p_on; force_wr_o && force_val_o |-> $past(go_on); endproperty
  a_on: assert property (p_on)
    else $error("forced set without command");
  property p_off; force_wr_o && !force_val_o |-> $past(go_off); endproperty
  a_off: assert property (p_off)
    else $error("forced reset without command");
  property p_bit;
    force_wr_o && force_bank_o == BK_DELAY_COUNT |-> force_bit_o == 4'h0;
  endproperty
  a_bit: assert property (p_bit)
    else $error("flag force with nonzero bit");
  property p_clr; go_clr |=> force_clr_o && !force_wr_o; endproperty
  a_clr: assert property (p_clr)
    else $error("clear all not issued");
endmodule : hci_top_monitor

bind hci_top hci_top_monitor #(.HAS_EXT_STORE(HAS_EXT_STORE)) mon (.clk_i,
  .reset_n_i, .addr_i, .wdata_i, .wr_i, .prog_wr_o, .prog_tc_o, .prog_opnd_o,
  .prog_val_o, .force_wr_o, .force_bank_o, .force_word_o, .force_bit_o,
  .force_val_o, .force_clr_o, .mode_o);
`default_nettype wire

// ===== verif/hci_host_model.sv
// Host side model driving the interpreter's register port
`timescale 1ns/100ps
`default_nettype none
module hci_host_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output var logic [hci_pkg::ADDR_W-1:0] addr_o,
  output var logic [hci_pkg::DATA_W-1:0] wdata_o,
  output var logic wr_o,
  output var logic rd_o,
  input wire logic [hci_pkg::DATA_W-1:0] rdata_i
);
  import hci_pkg::*;
  // Idle bus at time zero
  initial
  begin
    addr_o = 4'h0;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // One write cycle; data scrambled after so stale values never match
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : wr_reg
  // Read strobe, data taken in the following cycle only
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask : rd_reg
endmodule : hci_host_model
`default_nettype wire

// ===== verif/tb_hci_top.sv
// Self-checking testbench of the host command interpreter
`timescale 1ns/100ps
`default_nettype none
module tb_hci_top;
  import hci_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic wr_i, rd_i, prog_wr_o, force_wr_o, force_val_o, force_clr_o;
  logic alarm_valid_i = 1'b0;
  logic [7:0] prog_size_i = 8'h00;
  logic [7:0] alarm_num_i = 8'h00;
  logic [31:0] err_evt_i = 32'h0;
  logic [19:0] prog_addr_o;
  logic [15:0] prog_tc_o, prog_val_o, force_word_o;
  logic [3:0] force_bit_o;
  logic [1:0] mode_o;
  hci_instr_e prog_instr_o;
  hci_bank_e prog_opnd_o, force_bank_o;
  int failures = 0;
  int comparisons = 0;
  int i, j, w, b, pa, tc;
  logic [31:0] r, r1;
  logic [7:0] ec;
  logic p_s, f_s, c_s;
  logic [63:0] ps, fs;
  // Bank tables; delay/count flags last
  logic [31:0] fnm [5] = '{NM_IO, NM_LINK, NM_HOLD, NM_AUX, NM_DELAY};
  int flim [5] = '{252, 63, 99, 27, 511};
  hci_bank_e fbk [5] = '{BK_IO, BK_LINK, BK_HOLD, BK_AUX, BK_DELAY_COUNT};
  logic [31:0] inm [5] = '{NM_DELAY, NM_FAST_DELAY, NM_ACC_DELAY,
    NM_DOWN_COUNT, NM_UPDN_COUNT};
  logic [31:0] onm [7] = '{NM_LITERAL, NM_DATA, NM_DATA_IND, NM_IO,
    NM_LINK, NM_HOLD, NM_AUX};
  int olim [7] = '{9999, 6655, 6655, 252, 63, 99, 27};
  hci_bank_e obk [7] = '{BK_LITERAL, BK_DATA, BK_DATA_IND, BK_IO, BK_LINK,
    BK_HOLD, BK_AUX};

  hci_top #(.HAS_EXT_STORE(1'b0)) uut (.clk_i, .reset_n_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .prog_size_i, .alarm_valid_i, .alarm_num_i,
    .err_evt_i, .prog_wr_o, .prog_addr_o, .prog_instr_o, .prog_tc_o,
    .prog_opnd_o, .prog_val_o, .force_wr_o, .force_bank_o, .force_word_o,
    .force_bit_o, .force_val_o, .force_clr_o, .mode_o);
  hci_host_model host (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // Decimal to packed BCD, five digits
  function automatic logic [19:0] bcd(input int n);
    logic [19:0] v;
    v = 20'h0;
    for (int k = 0; k < 5; k++)
      v[k*4 +: 4] = 4'((n / (10 ** k)) % 10);
    return v;
  endfunction : bcd
  // Run one command; pulses are caught in the cycle they stand
  task automatic exec(input logic [3:0] code);
    host.wr_reg(REG_CMD, {28'h0, code});
    #1;
    {p_s, f_s, c_s} = {prog_wr_o, force_wr_o, force_clr_o};
    ps = {prog_addr_o, prog_instr_o, prog_tc_o, prog_opnd_o, prog_val_o};
    fs = {force_bank_o, force_word_o, force_bit_o, force_val_o};
    host.rd_reg(REG_END, r);
    ec = r[7:0];
  endtask : exec
  task automatic setp(input logic [31:0] nm, on, input int a, t, v);
    host.wr_reg(REG_NAME, nm);
    host.wr_reg(REG_ADDR, {12'h0, bcd(a)});
    host.wr_reg(REG_NUM, {12'h0, bcd(t)});
    host.wr_reg(REG_OPND, on);
    host.wr_reg(REG_VAL, {12'h0, bcd(v)});
    exec(CMD_SETPOINT);
  endtask : setp
  task automatic frc(input logic [31:0] nm, input int a, bt,
    input logic [3:0] code);
    host.wr_reg(REG_NAME, nm);
    host.wr_reg(REG_ADDR, {12'h0, bcd(a)});
    host.wr_reg(REG_NUM, {12'h0, bcd(bt)});
    exec(code);
  endtask : frc
  task automatic mode_w(input logic [7:0] mb, e, input logic [1:0] m);
    host.wr_reg(REG_VAL, {24'h0, mb});
    exec(CMD_MODE_WRITE);
    chk("mode_write", {ec, mode_o}, {e, m});
  endtask : mode_w
  task automatic fault(input logic [7:0] cp);
    host.wr_reg(REG_VAL, {24'h0, cp});
    exec(CMD_FAULT_READ);
    host.rd_reg(REG_RESP0, r);
    host.rd_reg(REG_RESP1, r1);
  endtask : fault

  // Guard against a hang
  initial
  begin
    repeat (100000) @(posedge clk_i);
    failures++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    r = $urandom(26);
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    host.rd_reg(REG_END, r);
    chk("reset", {r, mode_o}, {32'h0, MODE_RESET});
    $display("test reset done");
    // Top word, one past it, random word, in every bank
    for (int k = 0; k < 15; k++)
    begin
      i = k % 5;
      j = k / 5;
      w = (j == 0) ? flim[i] : (j == 1) ? flim[i] + 1 : $urandom_range(flim[i]);
      b = (i == 4) ? 0 : $urandom_range(15);
      frc(fnm[i], w, b, (k % 2) ? CMD_FORCE_OFF : CMD_FORCE_ON);
      chk("force_end", {f_s, ec}, (j == 1) ? END_RANGE_ERR : 9'h100);
      if (j != 1)
        chk("force_f", fs, {fbk[i], 16'(bcd(w)), 4'(b), k % 2 == 0});
    end
    $display("test force done");
    for (int k = 0; k < 7; k++)
    begin
      w = (k == 0) ? olim[k] : $urandom_range(olim[k]);
      pa = (k == 1) ? 99999 : $urandom_range(99999);
      tc = (k == 2) ? 511 : $urandom_range(511);
      setp(inm[k % 5], onm[k], pa, tc, w);
      chk("setp_end", {p_s, ec}, 9'h100);
      chk("setp_f", ps, {bcd(pa), 3'(k % 5 + 1), 16'(bcd(tc)),
        obk[k], 16'(bcd(w))});
    end
    // Refused setpoints leave memory untouched
    setp(NM_DELAY, NM_EXT, 100, 5, 10);
    chk("ext_refused", {p_s, ec}, END_NAME_ERR);
    setp(NM_DELAY, NM_DATA, 100, 5, 6656);
    chk("data_range", {p_s, ec}, END_RANGE_ERR);
    setp(NM_DELAY, NM_IO, 100, 5, 253);
    chk("io_range", {p_s, ec}, END_RANGE_ERR);
    setp(32'h54494D58, NM_LITERAL, 100, 5, 10);
    chk("bad_name", {p_s, ec}, END_NAME_ERR);
    $display("test setpoint done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      prog_size_i <= 8'($urandom);
      alarm_valid_i <= k[0];
      alarm_num_i <= 8'($urandom_range(255, 1));
      exec(CMD_STATE_QUERY);
      host.rd_reg(REG_RESP0, r);
      chk("status", r[15:0], {MODE_RESET, 6'h0, prog_size_i});
      host.rd_reg(REG_RESP1, r);
      chk("alarm", r[8:0], k ? {1'b1, alarm_num_i} : 9'h0);
    end
    $display("test status done");
    for (int k = 1; k < 4; k++)
      mode_w({2'(k), 6'h00}, END_OK, 2'(k));
    mode_w(8'h41, END_RANGE_ERR, 2'h3);
    // Fatal and non-fatal error raised outside program mode
    @(posedge clk_i);
    err_evt_i <= 32'h00010001;
    @(posedge clk_i);
    err_evt_i <= 32'h0;
    fault(CLR_YES);
    chk("fatal_kept", {ec, r}, 40'h0000010000);
    mode_w(8'h00, END_OK, MODE_PROGRAM);
    fault(8'h02);
    chk("bad_param", ec, END_RANGE_ERR);
    fault(CLR_NO);
    chk("no_clear", {ec, r, r1[0]}, 41'h0000020000);
    fault(CLR_YES);
    chk("cleared", {ec, r, r1[0]}, 41'h1);
    $display("test mode and faults done");
    exec(CMD_FORCE_CLEAR_ALL);
    chk("clear_all", {c_s, f_s, ec}, {2'b10, END_OK});
    exec(4'hF);
    chk("bad_cmd", {p_s, f_s, c_s, ec}, END_CMD_ERR);
    host.wr_reg(REG_END, 32'h0);
    host.rd_reg(REG_END, r);
    chk("end_ro", r, END_CMD_ERR);
    host.rd_reg(4'hF, r);
    chk("unmapped", r, 0);
    $display("test misc done");
    end_sim();
  end
endmodule : tb_hci_top
`default_nettype wire
